// [hw/pfcir_defs.vh]
// constants of the line-protection configuration bank: offsets, fields, resets, timing counts
// assumes a 100 MHz core clock; included by bare name from the design files
`ifndef PFCIR_DEFS_VH
`define PFCIR_DEFS_VH

// register offsets on the command port
`define PFCIR_ADDR_INRUSH 16'hfe2e
`define PFCIR_ADDR_OV_RISE 16'hfe2f
`define PFCIR_ADDR_OV_FALL 16'hfe30
`define PFCIR_ADDR_OV_DEB 16'hfe31
`define PFCIR_ADDR_LOWPWR 16'hfe32

// field positions
`define PFCIR_UVWIN_HI 4
`define PFCIR_UVWIN_LO 3
`define PFCIR_INDLY_HI 2
`define PFCIR_INDLY_LO 0
`define PFCIR_OVCODE_HI 6
`define PFCIR_DEB_HI 1

// reset values
`define PFCIR_RST_INRUSH 8'h00
`define PFCIR_RST_OV_RISE 8'h00
`define PFCIR_RST_OV_FALL 8'h00
`define PFCIR_RST_OV_DEB 8'h00
`define PFCIR_RST_LOWPWR 8'h00

// timing
`define PFCIR_CLK_MHZ 100
`define PFCIR_DEB0_NS 120
`define PFCIR_DEB1_NS 240
`define PFCIR_DEB2_NS 480
`define PFCIR_DEB3_NS 640
`define PFCIR_DEB0_CYC ((`PFCIR_DEB0_NS * `PFCIR_CLK_MHZ) / 1000)
`define PFCIR_DEB1_CYC ((`PFCIR_DEB1_NS * `PFCIR_CLK_MHZ) / 1000)
`define PFCIR_DEB2_CYC ((`PFCIR_DEB2_NS * `PFCIR_CLK_MHZ) / 1000)
`define PFCIR_DEB3_CYC ((`PFCIR_DEB3_NS * `PFCIR_CLK_MHZ) / 1000)
`define PFCIR_UVWIN2_US 2000
`define PFCIR_UVWIN4_US 4000
// window lengths in core cycles at 100 MHz, sized to the 24-bit window counter
`define PFCIR_UVWIN2_CYC 24'h03_0d40
`define PFCIR_UVWIN4_CYC 24'h06_1a80

`endif

// [hw/pfcir_pin_filter.v]
// three-flop pin synchroniser followed by a programmable debounce
// assumes the pin is asynchronous to core_clk_i; level_o follows after thr_i stable cycles
module pfcir_pin_filter (
	input wire core_clk_i, // core clock
	input wire rstn_i, // async reset, active low
	input wire pin_i, // raw pin level
	input wire [6:0] thr_i, // cycles the level must persist, at least 1
	output reg level_o // filtered level
);

	reg s1; // first stage, read only by s2
	reg s2; // second stage
	reg s3; // third stage
	reg agreed; // level once s2 and s3 agree
	reg [6:0] cnt; // persistence counter

	// synchroniser chain; a change counts only when the last two stages agree
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			agreed <= 1'b0;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				agreed <= s3;
			end
		end
	end

	// debounce: a glitch shorter than thr_i cycles restarts the count and is dropped
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 7'h00;
			level_o <= 1'b0;
		end else if (agreed == level_o) begin
			cnt <= 7'h00; // nothing pending
		end else if (cnt + 7'h01 >= thr_i) begin
			level_o <= agreed; // persisted long enough
			cnt <= 7'h00;
		end else begin
			cnt <= cnt + 7'h01;
		end
	end

endmodule

// [hw/pfcir_cfg.v]
// line-protection configuration bank: inrush timing, fast overvoltage setup, low power entry
// assumes a command port driven by the bus engine on core_clk_i, analog pins asynchronous
`include "pfcir_defs.vh"

// Function
// - undervoltage window: quarter, half cycle, 2ms, 4ms
// - inrush waits coded full line cycles after loss
// - rising trip code sent to overvoltage comparator
// - falling trip code sent likewise, same scale
// - overvoltage persists 120/240/480/640 ns before acting
// - low power when input power below threshold
// - soft start waits coded cycles after inrush
module pfcir_cfg #(
	parameter [23:0] UVWIN2_CYC = `PFCIR_UVWIN2_CYC, // 2 ms window in cycles
	parameter [23:0] UVWIN4_CYC = `PFCIR_UVWIN4_CYC // 4 ms window in cycles
) (
	input wire core_clk_i, // core clock, 100 MHz
	input wire rstn_i, // async reset, active low
	input wire [15:0] reg_addr_i, // command code
	input wire [7:0] reg_wdata_i, // write data
	input wire reg_wr_i, // write strobe, one cycle
	input wire reg_rd_i, // read strobe, one cycle
	output reg [7:0] reg_rdata_o, // read data
	output reg reg_rvalid_o, // read data valid pulse
	input wire vin_polarity_i, // ac input sign comparator pin
	input wire vin_below_i, // input-below-level comparator pin
	input wire fast_overvoltage_input_i, // fast overvoltage comparator pin
	input wire line_loss_flag_i, // line loss flag from line monitor
	input wire [2:0] soft_start_delay_i, // soft start delay code, full cycles
	input wire [7:0] input_power_i, // measured input power
	output wire [6:0] ov_rise_code_o, // rising trip code to comparator dac
	output wire [6:0] ov_fall_code_o, // falling trip code to comparator dac
	output reg ov_fault_o, // debounced overvoltage
	output reg input_undervoltage_flag_o, // undervoltage flag
	output reg inrush_o, // inrush signal
	output reg soft_start_o, // soft start begin level
	output reg low_power_mode_o // low power mode
);

	localparam [1:0] ST_LOSS = 2'b00; // line lost
	localparam [1:0] ST_HOLD = 2'b01; // waiting before inrush
	localparam [1:0] ST_SSWAIT = 2'b10; // inrush on, waiting for soft start
	localparam [1:0] ST_RUN = 2'b11; // soft start begun

	reg [7:0] inrush_timing_cfg; // window and inrush delay
	reg [7:0] overvoltage_rise_threshold; // rising code
	reg [7:0] overvoltage_fall_threshold; // falling code
	reg [7:0] overvoltage_debounce_cfg; // debounce select
	reg [7:0] low_power_entry_threshold; // low power threshold
	reg [7:0] next_rdata; // read mux
	reg [1:0] state; // sequencing state
	reg [2:0] cyc_cnt; // full line cycles counted
	reg pol_d; // previous filtered polarity
	reg [23:0] period_cnt; // running line period counter
	reg [23:0] line_period; // last measured full period
	reg [23:0] uv_cnt; // cycles the input stayed low
	reg [23:0] uv_win; // selected window length
	wire pol_f; // filtered polarity
	wire below_f; // filtered input-below level
	wire ov_f; // debounced overvoltage level
	wire full_cross; // rising zero crossing pulse
	wire [6:0] deb_thr; // selected debounce count

	// decode debounce select into a cycle count
	function [6:0] deb_cycles;
		input [1:0] sel;
		integer cyc; // count at integer width, cut to the threshold width below
		begin
			case (sel)
				2'b00: cyc = `PFCIR_DEB0_CYC;
				2'b01: cyc = `PFCIR_DEB1_CYC;
				2'b10: cyc = `PFCIR_DEB2_CYC;
				default: cyc = `PFCIR_DEB3_CYC;
			endcase
			deb_cycles = cyc[6:0]; // longest count is 64, fits in 7 bits
		end
	endfunction

	// true when the line cycle count has reached a delay code
	function delay_done;
		input [2:0] cnt;
		input [2:0] code;
		begin
			delay_done = (cnt >= code);
		end
	endfunction

	// register writes; reserved bits are never stored so they read as zero
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			inrush_timing_cfg <= `PFCIR_RST_INRUSH;
			overvoltage_rise_threshold <= `PFCIR_RST_OV_RISE;
			overvoltage_fall_threshold <= `PFCIR_RST_OV_FALL;
			overvoltage_debounce_cfg <= `PFCIR_RST_OV_DEB;
			low_power_entry_threshold <= `PFCIR_RST_LOWPWR;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`PFCIR_ADDR_INRUSH: inrush_timing_cfg <= {3'b000, reg_wdata_i[4:0]};
				`PFCIR_ADDR_OV_RISE: overvoltage_rise_threshold <= {1'b0, reg_wdata_i[6:0]};
				`PFCIR_ADDR_OV_FALL: overvoltage_fall_threshold <= {1'b0, reg_wdata_i[6:0]};
				`PFCIR_ADDR_OV_DEB: overvoltage_debounce_cfg <= {6'b00_0000, reg_wdata_i[1:0]};
				`PFCIR_ADDR_LOWPWR: low_power_entry_threshold <= reg_wdata_i;
				default: ; // unmapped writes are dropped
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always @* begin
		case (reg_addr_i)
			`PFCIR_ADDR_INRUSH: next_rdata = inrush_timing_cfg;
			`PFCIR_ADDR_OV_RISE: next_rdata = overvoltage_rise_threshold;
			`PFCIR_ADDR_OV_FALL: next_rdata = overvoltage_fall_threshold;
			`PFCIR_ADDR_OV_DEB: next_rdata = overvoltage_debounce_cfg;
			`PFCIR_ADDR_LOWPWR: next_rdata = low_power_entry_threshold;
			default: next_rdata = 8'h00;
		endcase
	end

	// read data registered, valid one cycle after the strobe
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

	// threshold codes go straight to the analog dac; scale is code*0.492/128 + 1 V
	assign ov_rise_code_o = overvoltage_rise_threshold[6:0];
	assign ov_fall_code_o = overvoltage_fall_threshold[6:0];

	assign deb_thr = deb_cycles(overvoltage_debounce_cfg[1:0]);

	// fast overvoltage path with selectable persistence
	pfcir_pin_filter u_ov_filt (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.pin_i(fast_overvoltage_input_i),
		.thr_i(deb_thr),
		.level_o(ov_f)
	);

	// polarity path; one cycle of persistence keeps crossing timing tight
	pfcir_pin_filter u_pol_filt (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.pin_i(vin_polarity_i),
		.thr_i(7'h01),
		.level_o(pol_f)
	);

	// input-below comparator path
	pfcir_pin_filter u_uv_filt (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.pin_i(vin_below_i),
		.thr_i(7'h01),
		.level_o(below_f)
	);

	assign full_cross = pol_f & ~pol_d;

	// line period measured between rising crossings; saturates if the line stops
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pol_d <= 1'b0;
			period_cnt <= 24'h00_0000;
			line_period <= 24'h00_0000;
		end else begin
			pol_d <= pol_f;
			if (full_cross) begin
				line_period <= period_cnt;
				period_cnt <= 24'h00_0001;
			end else if (period_cnt != 24'hff_ffff) begin
				period_cnt <= period_cnt + 24'h00_0001;
			end
		end
	end

	// window select; cycle-based windows follow the measured period
	always @* begin
		case (inrush_timing_cfg[`PFCIR_UVWIN_HI:`PFCIR_UVWIN_LO])
			2'b00: uv_win = {2'b00, line_period[23:2]};
			2'b01: uv_win = {1'b0, line_period[23:1]};
			2'b10: uv_win = UVWIN2_CYC;
			default: uv_win = UVWIN4_CYC;
		endcase
	end

	// flag set once the input has stayed low for a full window; until a period is
	// measured the cycle-based windows are zero, so the flag tracks the comparator
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			uv_cnt <= 24'h00_0000;
			input_undervoltage_flag_o <= 1'b0;
		end else if (!below_f) begin
			uv_cnt <= 24'h00_0000;
			input_undervoltage_flag_o <= 1'b0;
		end else begin
			if (uv_cnt != 24'hff_ffff) begin
				uv_cnt <= uv_cnt + 24'h00_0001;
			end
			input_undervoltage_flag_o <= (uv_cnt >= uv_win);
		end
	end

	// inrush and soft start sequencing; line loss aborts from any state
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= ST_LOSS;
			cyc_cnt <= 3'b000;
			inrush_o <= 1'b0;
			soft_start_o <= 1'b0;
		end else if (line_loss_flag_i) begin
			state <= ST_LOSS;
			cyc_cnt <= 3'b000;
			inrush_o <= 1'b0;
			soft_start_o <= 1'b0;
		end else begin
			case (state)
				ST_LOSS: begin
					state <= ST_HOLD; // flag has fallen
					cyc_cnt <= 3'b000;
				end
				ST_HOLD: begin
					if (delay_done(cyc_cnt, inrush_timing_cfg[`PFCIR_INDLY_HI:`PFCIR_INDLY_LO])) begin
						inrush_o <= 1'b1;
						state <= ST_SSWAIT;
						cyc_cnt <= 3'b000;
					end else if (full_cross) begin
						cyc_cnt <= cyc_cnt + 3'b001;
					end
				end
				ST_SSWAIT: begin
					if (delay_done(cyc_cnt, soft_start_delay_i)) begin
						soft_start_o <= 1'b1;
						state <= ST_RUN;
					end else if (full_cross) begin
						cyc_cnt <= cyc_cnt + 3'b001;
					end
				end
				ST_RUN: state <= ST_RUN; // hold until line loss
				default: state <= ST_LOSS;
			endcase
		end
	end

	// debounced overvoltage and low power compare, registered
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ov_fault_o <= 1'b0;
			low_power_mode_o <= 1'b0;
		end else begin
			ov_fault_o <= ov_f;
			low_power_mode_o <= (input_power_i < low_power_entry_threshold);
		end
	end

endmodule

// [tb/pfcir_cfg_assertions.sv]
// checker for the line-protection bank, bound onto pfcir_cfg
// assumes it sees only the top ports; one clock domain
module pfcir_cfg_chk (
	input wire logic core_clk_i, // clock
	input wire logic rstn_i, // reset, active low
	input wire logic [15:0] reg_addr_i, // command code
	input wire logic [7:0] reg_wdata_i, // write data
	input wire logic reg_wr_i, // write strobe
	input wire logic line_loss_flag_i, // loss level
	input wire logic fast_overvoltage_input_i, // overvoltage pin
	input wire logic vin_below_i, // below pin
	input wire logic [7:0] input_power_i, // input power
	input wire logic [6:0] ov_rise_code_o, // rise code
	input wire logic [6:0] ov_fall_code_o, // fall code
	input wire logic ov_fault_o, // debounced overvoltage
	input wire logic input_undervoltage_flag_o, // undervoltage flag
	input wire logic inrush_o, // inrush
	input wire logic soft_start_o, // soft start
	input wire logic low_power_mode_o // low power
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);
	logic [7:0] run; // length of the latest high run on the pin
	logic pin_q; // pin one cycle ago
	logic [1:0] deb_sel; // debounce code as last written
	logic [7:0] lp_thr; // low power threshold as last written
	logic [7:0] deb_min; // shortest persistence allowed for the code
	// shadow copies taken from the writes seen on the port; reset values are zero
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			deb_sel <= 2'b00;
			lp_thr <= 8'h00;
		end else if (reg_wr_i && reg_addr_i == 16'hfe31) begin
			deb_sel <= reg_wdata_i[1:0];
		end else if (reg_wr_i && reg_addr_i == 16'hfe32) begin
			lp_thr <= reg_wdata_i;
		end
	end
	// 120/240/480/640 ns at a 10 ns clock
	always_comb begin
		case (deb_sel)
			2'b00: deb_min = 8'h0c;
			2'b01: deb_min = 8'h18;
			2'b10: deb_min = 8'h30;
			default: deb_min = 8'h40;
		endcase
	end
	// the run survives the pin falling, because the fault lags the pin
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run <= 8'h00;
			pin_q <= 1'b0;
		end else begin
			pin_q <= fast_overvoltage_input_i;
			if (fast_overvoltage_input_i && !pin_q)
				run <= 8'h01;
			else if (fast_overvoltage_input_i && run != 8'hff)
				run <= run + 8'h01;
		end
	end
	a_rise_code_out: assert property (reg_wr_i && reg_addr_i == 16'hfe2f |=>
		ov_rise_code_o == $past(reg_wdata_i[6:0])) else $error("rise code not taken");
	a_fall_code_out: assert property (reg_wr_i && reg_addr_i == 16'hfe30 |=>
		ov_fall_code_o == $past(reg_wdata_i[6:0])) else $error("fall code not taken");
	a_low_power_top: assert property (input_power_i == 8'hff |=> !low_power_mode_o)
		else $error("low power at full input");
	a_inrush_loss: assert property (line_loss_flag_i |=> !inrush_o && !soft_start_o)
		else $error("inrush during loss");
	a_inrush_min_wait: assert property ($fell(line_loss_flag_i) |-> !inrush_o ##1 !inrush_o)
		else $error("inrush too early");
	a_soft_after_inrush: assert property ($rose(soft_start_o) |-> $past(inrush_o))
		else $error("soft start without inrush");
	a_ov_debounce: assert property ($rose(ov_fault_o) |-> run >= 8'h0c)
		else $error("fault on short pulse");
	a_ov_persist: assert property ($rose(ov_fault_o) |-> run >= deb_min)
		else $error("fault before debounce time");
	a_low_power_track: assert property (low_power_mode_o == $past(input_power_i < lp_thr))
		else $error("low power mode does not follow threshold");
	a_uv_clear: assert property (!vin_below_i [*8] |-> !input_undervoltage_flag_o)
		else $error("flag held while input above");
	c_inrush: cover property ($rose(inrush_o));
	c_fault: cover property ($rose(ov_fault_o));
	c_uv: cover property ($rose(input_undervoltage_flag_o));
endmodule
bind pfcir_cfg pfcir_cfg_chk pfcir_cfg_chk_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.line_loss_flag_i(line_loss_flag_i), .fast_overvoltage_input_i(fast_overvoltage_input_i),
	.vin_below_i(vin_below_i), .input_power_i(input_power_i), .ov_rise_code_o(ov_rise_code_o),
	.ov_fall_code_o(ov_fall_code_o), .ov_fault_o(ov_fault_o), .inrush_o(inrush_o),
	.input_undervoltage_flag_o(input_undervoltage_flag_o), .soft_start_o(soft_start_o),
	.low_power_mode_o(low_power_mode_o));

// [tb/pfcir_host.sv]
// host model: reaches the bank through its strobe port
// assumes strobes are one-cycle pulses, read data one cycle later
module pfcir_host (
	input wire logic core_clk_i, // clock
	input wire logic [7:0] reg_rdata_i, // read data
	input wire logic reg_rvalid_i, // read valid
	output logic [15:0] reg_addr_o, // command code
	output logic [7:0] reg_wdata_o, // write data
	output logic reg_wr_o, // write strobe
	output logic reg_rd_o // read strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle port at time zero
	initial begin
		reg_addr_o = 16'h0000;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end
	// one write, strobe dropped after the taking edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(posedge core_clk_i);
		#1;
		reg_wr_o = 1'b0;
	endtask
	// one read; a missing valid returns unknowns so the compare fails
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		#1;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(posedge core_clk_i);
		#1;
		reg_rd_o = 1'b0;
		d = reg_rvalid_i ? reg_rdata_i : 8'hxx;
	endtask
endmodule

// [tb/pfcir_cfg_tb.sv]
// self-checking bench of the line-protection bank
// assumes a 100 MHz clock and shortened undervoltage windows
module pfcir_cfg_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W2 = 200; // short 2 ms window
	localparam int W4 = 400; // short 4 ms window
	logic clk, rstn, wr, rd, rv, pol, below, ovin, loss, flt, uv, inr, ss, lp;
	logic [15:0] addr;
	logic [7:0] wd, rdat, pwr;
	logic [6:0] rise, fall;
	logic [2:0] ssd;
	int errors, total_checks;
	// addr, write data, read back
	logic [31:0] rows [6] = '{32'hfe2e_ff1f, 32'hfe2f_ff7f, 32'hfe30_d555, 32'hfe31_ff03,
		32'hfe32_a5a5, 32'hfe33_ff00};
	// window code, cycles below, flag; line period is 200 cycles
	int uvr [7][3] = '{'{0, 80, 1}, '{1, 80, 0}, '{1, 130, 1}, '{2, 150, 0}, '{2, 250, 1},
		'{3, 300, 0}, '{3, 450, 1}};
	int nd [4] = '{12, 24, 48, 64}; // debounce cycles per code
	pfcir_cfg #(.UVWIN2_CYC(W2[23:0]), .UVWIN4_CYC(W4[23:0])) pfcir_cfg_inst (.core_clk_i(clk),
		.rstn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdat), .reg_rvalid_o(rv), .vin_polarity_i(pol), .vin_below_i(below),
		.fast_overvoltage_input_i(ovin), .line_loss_flag_i(loss), .soft_start_delay_i(ssd),
		.input_power_i(pwr), .ov_rise_code_o(rise), .ov_fall_code_o(fall), .ov_fault_o(flt),
		.input_undervoltage_flag_o(uv), .inrush_o(inr), .soft_start_o(ss), .low_power_mode_o(lp));
	pfcir_host pfcir_host_inst (.core_clk_i(clk), .reg_rdata_i(rdat), .reg_rvalid_i(rv),
		.reg_addr_o(addr), .reg_wdata_o(wd), .reg_wr_o(wr), .reg_rd_o(rd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ac line: sign pin toggles every 100 cycles
	initial begin
		pol = 1'b0;
		forever begin
			repeat (100) @(posedge clk);
			#1 pol = ~pol;
		end
	end
	task automatic stop_test();
		if (errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// wait n edges, then step off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	initial begin
		#100000;
		errors++;
		stop_test();
	end
	initial begin
		logic [7:0] d;
		{rstn, below, ovin, loss, ssd, pwr} = '0;
		cyc(6);
		rstn = 1'b1;
		for (int i = 0; i < 5; i++) begin
			pfcir_host_inst.rd(16'hfe2e + 16'(i), d);
			chk(d, 8'h00);
		end
		// reserved bits and an unmapped place read zero
		foreach (rows[i]) begin
			pfcir_host_inst.wr(rows[i][31:16], rows[i][15:8]);
			pfcir_host_inst.rd(rows[i][31:16], d);
			chk(d, rows[i][7:0]);
		end
		// distinct codes, so a swapped pair of trip outputs shows
		chk({1'b0, rise}, 8'h7f);
		chk({1'b0, fall}, 8'h55);
		cyc(400);
		foreach (uvr[i]) begin
			pfcir_host_inst.wr(16'hfe2e, {3'b000, uvr[i][0][1:0], 3'b000});
			below = 1'b1;
			cyc(uvr[i][1]);
			chk({7'h00, uv}, uvr[i][2][7:0]);
			below = 1'b0;
			cyc(10);
		end
		// inrush after three crossings, soft start one later
		pfcir_host_inst.wr(16'hfe2e, 8'h03);
		ssd = 3'h1;
		loss = 1'b1;
		@(posedge pol);
		cyc(50);
		chk({6'h00, inr, ss}, 8'h00);
		loss = 1'b0;
		repeat (2) @(posedge pol);
		cyc(10);
		chk({6'h00, inr, ss}, 8'h00);
		@(posedge pol);
		cyc(10);
		chk({6'h00, inr, ss}, 8'h02);
		@(posedge pol);
		cyc(10);
		chk({6'h00, inr, ss}, 8'h03);
		// threshold boundary: equal is not below
		pfcir_host_inst.wr(16'hfe32, 8'h40);
		pwr = 8'h3f;
		cyc(3);
		chk({7'h00, lp}, 8'h01);
		pwr = 8'h40;
		cyc(3);
		chk({7'h00, lp}, 8'h00);
		pwr = 8'hff;
		cyc(3);
		foreach (nd[c]) begin
			pfcir_host_inst.wr(16'hfe31, 8'(c));
			ovin = 1'b1;
			cyc(nd[c] - 6);
			ovin = 1'b0;
			cyc(10);
			chk({7'h00, flt}, 8'h00);
			ovin = 1'b1;
			cyc(nd[c] + 10);
			chk({7'h00, flt}, 8'h01);
			ovin = 1'b0;
			cyc(nd[c] + 10);
		end
		// reset in mid-run: sequencing outputs, trip codes and the inrush register return to zero
		rstn = 1'b0;
		cyc(2);
		chk({2'b00, inr, ss, flt, lp, uv, rv}, 8'h00);
		chk({1'b0, rise | fall}, 8'h00);
		rstn = 1'b1;
		pfcir_host_inst.rd(16'hfe2e, d);
		chk(d, 8'h00);
		stop_test();
	end
endmodule
